// ### design/ssl_pkg.sv
package ssl_pkg;
  localparam logic [7:0] SUPPLY_STATUS_OFF  = 8'h30;
  localparam logic [7:0] CORE_TARGET_OFF    = 8'h34;
  localparam logic [7:0] PLL_TARGET_OFF     = 8'h40;
  localparam int         OSC_STABLE_BIT     = 24;
  localparam int         PLL_GOOD_BIT       = 19;
  localparam int         CORE_GOOD_BIT      = 16;
  localparam int         ANA_LIMIT_BIT      = 9;
  localparam int         CORE_LIMIT_BIT     = 8;
  localparam int         ANA_SOFT_BIT       = 1;
  localparam int         CORE_SOFT_BIT      = 0;
  localparam int         CORE_TARGET_W      = 7;
  localparam int         PLL_TARGET_W       = 3;
  localparam logic [6:0] CORE_TARGET_MAX    = 7'h46;
  localparam logic [2:0] PLL_TARGET_MAX     = 3'h6;
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;
endpackage : ssl_pkg

// ### design/ssl_bus_if.sv
`timescale 1ns/100ps
interface ssl_bus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;
  modport bus  (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
                input rd_data, input rd_ok, input wr_ok);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
                output rd_data, output rd_ok, output wr_ok);
endinterface : ssl_bus_if

// ### design/ssl_regs.sv
`timescale 1ns/100ps
module ssl_regs
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // register access
  ssl_bus_if.regs         rb,
  // live supply conditions
  input  wire logic       osc_stable,
  input  wire logic       pll_supply_good,
  input  wire logic       core_supply_good,
  input  wire logic       analogue_converter_limit,
  input  wire logic       core_converter_limit,
  input  wire logic       analogue_converter_soft,
  input  wire logic       core_converter_soft,
  // strap defaults
  input  wire logic [6:0] strap_core_target,
  input  wire logic [2:0] strap_pll_target,
  // targets
  output logic      [6:0] core_target,
  output logic      [2:0] pll_target
);
  logic       loaded_q;
  logic [6:0] core_q;
  logic [2:0] pll_q;
  logic [31:0] status;

  always_comb
  begin
    status = 32'h0000_0000;
    status[ssl_pkg::OSC_STABLE_BIT] = osc_stable;            // RL2
    status[ssl_pkg::PLL_GOOD_BIT]   = pll_supply_good;       // RL3
    status[ssl_pkg::CORE_GOOD_BIT]  = core_supply_good;      // RL4
    status[ssl_pkg::ANA_LIMIT_BIT]  = analogue_converter_limit; // RL5
    status[ssl_pkg::CORE_LIMIT_BIT] = core_converter_limit;  // RL5
    status[ssl_pkg::ANA_SOFT_BIT]   = analogue_converter_soft;  // RL6
    status[ssl_pkg::CORE_SOFT_BIT]  = core_converter_soft;   // RL6
  end

  // straps caught by a clocked load right after release, never by the async reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      loaded_q <= 1'b0;
    else
      loaded_q <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      core_q <= 7'h00;
    else if (!loaded_q)
      core_q <= strap_core_target;                           // RL11
    else if (rb.wr_en && rb.wr_addr == ssl_pkg::CORE_TARGET_OFF && rb.wr_strb[0])
      core_q <= rb.wr_data[6:0];                             // RL7
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pll_q <= 3'h0;
    else if (!loaded_q)
      pll_q <= strap_pll_target;                             // RL11
    else if (rb.wr_en && rb.wr_addr == ssl_pkg::PLL_TARGET_OFF && rb.wr_strb[0])
      pll_q <= rb.wr_data[2:0];                              // RL9
  end

  always_comb
  begin
    rb.rd_ok = 1'b1;
    if (rb.rd_addr == ssl_pkg::SUPPLY_STATUS_OFF)
      rb.rd_data = status;                                   // RL1
    else if (rb.rd_addr == ssl_pkg::CORE_TARGET_OFF)
      rb.rd_data = {25'h000_0000, core_q};                   // RL12
    else if (rb.rd_addr == ssl_pkg::PLL_TARGET_OFF)
      rb.rd_data = {29'h0000_0000, pll_q};                   // RL12
    else
    begin
      rb.rd_data = 32'h0000_0000;
      rb.rd_ok   = 1'b0;
    end
  end

  // status write is accepted but has no effect
  assign rb.wr_ok = (rb.wr_addr == ssl_pkg::SUPPLY_STATUS_OFF) ||
                    (rb.wr_addr == ssl_pkg::CORE_TARGET_OFF) ||
                    (rb.wr_addr == ssl_pkg::PLL_TARGET_OFF);   // RL12
  assign core_target = core_q;
  assign pll_target  = pll_q;

  chk_status_live: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
    rb.rd_addr == ssl_pkg::SUPPLY_STATUS_OFF |-> rb.rd_data[24] == osc_stable && rb.rd_data[0] == core_converter_soft)
    else $error("status word not live");
  chk_core_hold: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
    loaded_q && !(rb.wr_en && rb.wr_addr == ssl_pkg::CORE_TARGET_OFF) |=> $stable(core_q))
    else $error("core target changed without write");
  chk_strap_load: assert property (@(posedge core_clk) disable iff (!nrst) // RL11
    !loaded_q |=> core_q == $past(strap_core_target) && pll_q == $past(strap_pll_target))
    else $error("strap not loaded");
endmodule : ssl_regs

// ### design/ssl_top.sv
`timescale 1ns/100ps
// How it works
// RL1: status word at 0x30 is read-only and shows live supply conditions.
// RL2: bit 24 reads 1 when the on-die oscillator is stable.
// RL3: bit 19 reads 1 while the pll supply is good.
// RL4: bit 16 reads 1 while the core supply is good.
// RL5: bit 9 analogue converter limiting, bit 8 core converter limiting.
// RL6: bit 1 analogue converter soft-start, bit 0 core converter soft-start.
// RL7: writable 7-bit core target at 0x34, 10 mV per code from 0.60V.
// RL8: software should ramp core target at most 10 mV per microsecond.
// RL9: writable 3-bit pll regulator target at 0x40, 100 mV per code.
// RL10: software should raise regulator target one code at a time.
// RL11: both targets load from strap pins after reset.
// RL12: reserved bits read zero; writes to them and status are ignored.
module ssl_top
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // supply monitors
  input  wire logic        osc_stable,
  input  wire logic        pll_supply_good,
  input  wire logic        core_supply_good,
  input  wire logic        analogue_converter_limit,
  input  wire logic        core_converter_limit,
  input  wire logic        analogue_converter_soft,
  input  wire logic        core_converter_soft,
  // straps and targets
  input  wire logic [6:0]  strap_core_target,
  input  wire logic [2:0]  strap_pll_target,
  output logic      [6:0]  core_target,
  output logic      [2:0]  pll_target
);
  ssl_bus_if rb ();

  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end
    else if (wr_go)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_go)
      w_have_q <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssl_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rb.wr_ok ? ssl_pkg::RESP_OKAY : ssl_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read data sampled at acceptance so live status bits stay fixed while rvalid stands
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ssl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rb.rd_data;                            // RL1
      s_axi_rresp  <= rb.rd_ok ? ssl_pkg::RESP_OKAY : ssl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  assign rb.wr_en   = wr_go;
  assign rb.wr_addr = aw_addr_q;
  assign rb.wr_data = w_data_q;
  assign rb.wr_strb = w_strb_q;
  assign rb.rd_addr = {s_axi_araddr[7:2], 2'b00};

  ssl_regs u_regs
  (
    .core_clk                 (core_clk),
    .nrst                     (nrst),
    .rb                       (rb),
    .osc_stable               (osc_stable),
    .pll_supply_good          (pll_supply_good),
    .core_supply_good         (core_supply_good),
    .analogue_converter_limit (analogue_converter_limit),
    .core_converter_limit     (core_converter_limit),
    .analogue_converter_soft  (analogue_converter_soft),
    .core_converter_soft      (core_converter_soft),
    .strap_core_target        (strap_core_target),
    .strap_pll_target         (strap_pll_target),
    .core_target              (core_target),
    .pll_target               (pll_target)
  );

  chk_pll_good_bit: assert property (@(posedge core_clk) disable iff (!nrst) // RL3
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h0c |=> s_axi_rdata[19] == $past(pll_supply_good))
    else $error("pll good bit wrong");
  chk_core_good_bit: assert property (@(posedge core_clk) disable iff (!nrst) // RL4
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h0c |=> s_axi_rdata[16] == $past(core_supply_good))
    else $error("core good bit wrong");
  chk_osc_bit: assert property (@(posedge core_clk) disable iff (!nrst) // RL2
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h0c |=> s_axi_rdata[24] == $past(osc_stable))
    else $error("oscillator bit wrong");
  chk_limit_bits: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h0c |=>
    s_axi_rdata[9:8] == $past({analogue_converter_limit, core_converter_limit}))
    else $error("limit bits wrong");
  chk_soft_bits: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h0c |=>
    s_axi_rdata[1:0] == $past({analogue_converter_soft, core_converter_soft}))
    else $error("soft-start bits wrong");
  chk_core_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
    wr_go && aw_addr_q == 8'h34 && w_strb_q[0] |=> core_target == $past(w_data_q[6:0]))
    else $error("core target write lost");
  chk_pll_write: assert property (@(posedge core_clk) disable iff (!nrst) // RL9
    wr_go && aw_addr_q == 8'h40 && w_strb_q[0] |=> pll_target == $past(w_data_q[2:0]))
    else $error("pll target write lost");
  // the reserved mask depends on which word was read, so it is chosen from the accepted address
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
    s_axi_arvalid && s_axi_arready |=>
    (($past(s_axi_araddr[7:2]) == 6'h0c) ? ((s_axi_rdata & 32'hFEF6_FCFC) == 32'h0000_0000) :
     ($past(s_axi_araddr[7:2]) == 6'h0d) ? (s_axi_rdata[31:7] == 25'h000_0000) :
     (s_axi_rdata[31:3] == 29'h0000_0000)))
    else $error("reserved bits nonzero");
  chk_status_ro: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
    wr_go && aw_addr_q == 8'h30 |=> $stable(core_target) && $stable(pll_target))
    else $error("status write had effect");
  chk_status_wr_ok: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
    wr_go && aw_addr_q == 8'h30 |=> s_axi_bvalid && s_axi_bresp == ssl_pkg::RESP_OKAY)
    else $error("status write not answered okay");
  chk_unmapped_rd: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
    s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[7:2] != 6'h0c && s_axi_araddr[7:2] != 6'h0d && s_axi_araddr[7:2] != 6'h10 |=>
    s_axi_rresp == ssl_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_unmapped_wr: assert property (@(posedge core_clk) disable iff (!nrst) // RL12
    wr_go && aw_addr_q != 8'h30 && aw_addr_q != 8'h34 && aw_addr_q != 8'h40 |=>
    s_axi_bresp == ssl_pkg::RESP_SLVERR && $stable(core_target) && $stable(pll_target))
    else $error("unmapped write not refused");
  chk_strobe_off: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
    wr_go && aw_addr_q == 8'h34 && !w_strb_q[0] |=> $stable(core_target))
    else $error("core target changed without byte strobe");
  chk_mapped_rd_ok: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
    s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr[7:2] == 6'h0c || s_axi_araddr[7:2] == 6'h0d || s_axi_araddr[7:2] == 6'h10) |=>
    s_axi_rvalid && s_axi_rresp == ssl_pkg::RESP_OKAY)
    else $error("mapped read not answered okay");

  cov_status_read: cover property (@(posedge core_clk) disable iff (!nrst)
    s_axi_rvalid && s_axi_rready && s_axi_rdata[16]);
  cov_core_write: cover property (@(posedge core_clk) disable iff (!nrst)
    wr_go && aw_addr_q == 8'h34);
  cov_pll_write: cover property (@(posedge core_clk) disable iff (!nrst)
    wr_go && aw_addr_q == 8'h40);
  cov_bad_read: cover property (@(posedge core_clk) disable iff (!nrst)
    s_axi_rvalid && s_axi_rresp == 2'h2);
  cov_strobe_off: cover property (@(posedge core_clk) disable iff (!nrst)
    wr_go && aw_addr_q == 8'h34 && !w_strb_q[0]);
endmodule : ssl_top

// ### verif/supply_status_level_regs_bench.sv
`timescale 1ns/100ps
module supply_status_level_regs_bench;
  logic        core_clk, nrst, aw_v, aw_r, w_v, w_r, b_v, b_rdy, ar_v, ar_r, r_v, r_rdy;
  logic [7:0]  aw_a, ar_a;
  logic [31:0] w_d, r_d, rd;
  logic [3:0]  w_s;
  logic [1:0]  b_resp, r_resp, rs;
  logic [6:0]  mon, strap_core, core_t;
  logic [2:0]  strap_pll, pll_t;
  int          fail_count, total_checks;

  ssl_top u_dut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
    .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_bresp(b_resp),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a),
    .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .osc_stable(mon[6]), .pll_supply_good(mon[5]), .core_supply_good(mon[4]),
    .analogue_converter_limit(mon[3]), .core_converter_limit(mon[2]),
    .analogue_converter_soft(mon[1]), .core_converter_soft(mon[0]),
    .strap_core_target(strap_core), .strap_pll_target(strap_pll),
    .core_target(core_t), .pll_target(pll_t));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic hung(input string what);
    fail_count++;
    $display("ERROR %0t: no answer on %s", $time, what);
    test_done();
  endtask : hung

  // each bus task starts one edge late so no handshake signal is set twice in a step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic aw_p, w_p, got;
    @(posedge core_clk);
    aw_v <= 1'b1; aw_a <= a; w_v <= 1'b1; w_d <= d; w_s <= s; b_rdy <= 1'b1;
    aw_p = 1'b1; w_p = 1'b1; got = 1'b0; n = 0;
    while (!got)
    begin
      @(posedge core_clk);
      n++;
      if (n > 50) hung("write");
      if (aw_p && aw_r)
      begin
        aw_p = 1'b0;
        aw_v <= 1'b0;
      end
      if (w_p && w_r)
      begin
        w_p = 1'b0;
        w_v <= 1'b0;
      end
      if (!aw_p && !w_p && b_v)
      begin
        got = 1'b1;
        r = b_resp;
        b_rdy <= 1'b0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_p, got;
    @(posedge core_clk);
    ar_v <= 1'b1; ar_a <= a; r_rdy <= 1'b1;
    ar_p = 1'b1; got = 1'b0; n = 0;
    while (!got)
    begin
      @(posedge core_clk);
      n++;
      if (n > 50) hung("read");
      if (ar_p && ar_r)
      begin
        ar_p = 1'b0;
        ar_v <= 1'b0;
      end
      else if (!ar_p && r_v)
      begin
        got = 1'b1;
        d = r_d;
        r = r_resp;
        r_rdy <= 1'b0;
      end
    end
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string w);
    axi_rd(a, rd, rs);
    check(rd, e, w);
    check({30'h0, rs}, {30'h0, er}, "rresp");
  endtask : rd_chk

  // writes with every reserved bit set except the pll zero step; the wait keeps the ramp at one code per microsecond
  task automatic tgt_step(input logic [7:0] a, input logic [31:0] wd, input logic [31:0] e, input string w);
    axi_wr(a, wd, 4'hf, rs);
    check({30'h0, rs}, {30'h0, ssl_pkg::RESP_OKAY}, "bresp");
    rd_chk(a, e, ssl_pkg::RESP_OKAY, w);
    repeat (100) @(posedge core_clk);
  endtask : tgt_step

  task automatic do_reset;
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  initial
  begin
    int pos[7];
    pos = '{ssl_pkg::CORE_SOFT_BIT, ssl_pkg::ANA_SOFT_BIT, ssl_pkg::CORE_LIMIT_BIT, ssl_pkg::ANA_LIMIT_BIT,
            ssl_pkg::CORE_GOOD_BIT, ssl_pkg::PLL_GOOD_BIT, ssl_pkg::OSC_STABLE_BIT};
    nrst = 1'b0; aw_v = 1'b0; aw_a = 8'h00; w_v = 1'b0; w_d = 32'h0; w_s = 4'h0; b_rdy = 1'b0;
    ar_v = 1'b0; ar_a = 8'h00; r_rdy = 1'b0; mon = 7'h00; strap_core = 7'h3c; strap_pll = 3'h4;
    fail_count = 0; total_checks = 0;
    do_reset();
    check({25'h0, core_t}, 32'h3c, "core strap");
    check({29'h0, pll_t}, 32'h4, "pll strap");
    rd_chk(ssl_pkg::CORE_TARGET_OFF, 32'h3c, ssl_pkg::RESP_OKAY, "core rd");
    rd_chk(ssl_pkg::PLL_TARGET_OFF, 32'h4, ssl_pkg::RESP_OKAY, "pll rd");
    $display("test strap load done");
    for (int i = 0; i < 7; i++)
    begin
      mon <= 7'h01 << i;
      rd_chk(ssl_pkg::SUPPLY_STATUS_OFF, 32'h1 << pos[i], ssl_pkg::RESP_OKAY, "status");
    end
    mon <= 7'h7f;
    rd_chk(ssl_pkg::SUPPLY_STATUS_OFF, 32'h0109_0303, ssl_pkg::RESP_OKAY, "status all");
    axi_wr(ssl_pkg::SUPPLY_STATUS_OFF, 32'h0000_0000, 4'hf, rs);
    check({30'h0, rs}, {30'h0, ssl_pkg::RESP_OKAY}, "status wr");
    check({22'h0, core_t, pll_t}, {22'h0, 7'h3c, 3'h4}, "status wr side effect");
    mon <= 7'h00;
    rd_chk(ssl_pkg::SUPPLY_STATUS_OFF, 32'h0, ssl_pkg::RESP_OKAY, "status live");
    $display("test status done");
    for (int c = 61; c <= int'(ssl_pkg::CORE_TARGET_MAX); c++)
    begin
      tgt_step(ssl_pkg::CORE_TARGET_OFF, {25'h1ff_ffff, 7'(c)}, 32'(c), "core up");
      check({25'h0, core_t}, 32'(c), "core pin");
    end
    for (int c = 69; c >= 0; c--)
    begin
      tgt_step(ssl_pkg::CORE_TARGET_OFF, {25'h1ff_ffff, 7'(c)}, 32'(c), "core down");
      check({25'h0, core_t}, 32'(c), "core pin");
    end
    for (int c = 5; c <= int'(ssl_pkg::PLL_TARGET_MAX); c++)
    begin
      tgt_step(ssl_pkg::PLL_TARGET_OFF, {29'h1fff_ffff, 3'(c)}, 32'(c), "pll up");
      check({29'h0, pll_t}, 32'(c), "pll pin");
    end
    tgt_step(ssl_pkg::PLL_TARGET_OFF, 32'h0, 32'h0, "pll zero");
    $display("test targets done");
    axi_wr(ssl_pkg::CORE_TARGET_OFF, 32'h0000_0010, 4'he, rs);
    check({25'h0, core_t}, 32'h0, "strobe off");
    rd_chk(8'h38, 32'h0, ssl_pkg::RESP_SLVERR, "unmapped rd");
    axi_wr(8'h38, 32'hffff_ffff, 4'hf, rs);
    check({30'h0, rs}, {30'h0, ssl_pkg::RESP_SLVERR}, "unmapped wr");
    check({22'h0, core_t, pll_t}, 32'h0, "unmapped side effect");
    $display("test refusals done");
    strap_core <= ssl_pkg::CORE_TARGET_MAX;
    strap_pll <= ssl_pkg::PLL_TARGET_MAX;
    do_reset();
    check({25'h0, core_t}, 32'h46, "core strap 2");
    check({29'h0, pll_t}, 32'h6, "pll strap 2");
    $display("test re-strap done");
    test_done();
  end
endmodule : supply_status_level_regs_bench
